//--- hdl/flash_read_defines.vh
// opcodes, phase lengths and array limits for the multi-line flash read path
`ifndef FLASH_READ_DEFINES_VH
`define FLASH_READ_DEFINES_VH

// read opcodes taken on the single input line
`define OP_DUAL_OUT        8'h3B
`define OP_DUAL_IO         8'hBB
`define OP_QUAD_OUT        8'h6B
`define OP_QUAD_IO         8'hEB
// continuation reset opcode: value is a plain default, override by parameter
`define OP_MODE_RESET      8'hFF

// phase lengths in serial clocks
`define CMD_CLKS           5'd8
`define ADDR_CLKS_X1       5'd24
`define ADDR_CLKS_X2       5'd12
`define ADDR_CLKS_X4       5'd6
`define MODE_CLKS_X2       5'd4
`define MODE_CLKS_X4       5'd2
`define DUMMY_CLKS_X1      5'd8
`define DUMMY_CLKS_X4      5'd4

// continuation code field position and value inside the mode byte
`define CONT_FIELD_HI      5
`define CONT_FIELD_LO      4
`define CONT_CODE          2'h2

// array geometry
`define ARRAY_ADDR_W       19
`define ARRAY_LAST         19'h7FFFF
`define ARRAY_FIRST        19'h00000

// output enables (low = driving)
`define OE_NONE            4'hF
`define OE_DUAL            4'hC
`define OE_QUAD            4'h0

`endif

//--- hdl/pin_sync.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 6
) (
    input  wire             core_clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] pin_i,
    output wire [WIDTH-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg stage1;
            reg stage2;
            // first stage feeds only the second stage
            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    stage1 <= 1'b1;
                    stage2 <= 1'b1;
                end else begin
                    stage1 <= pin_i[g];
                    stage2 <= stage1;
                end
            end
            assign sync_o[g] = stage2;
        end
    endgenerate
endmodule // pin_sync

//--- hdl/multi_io_flash_read_path.v
// multi-line read path: dual/quad output and dual/quad i/o array reads
//
// How it works
// [RULE_01] dual-output read: opcode, address, dummy byte
// [RULE_02] dual data: bit7 on io1, four clocks
// [RULE_03] after last byte wrap to zero, no gap
// [RULE_04] chip select high ends read, release lines
// [RULE_05] dual-i/o read: address and mode two-bit
// [RULE_06] only upper mode nibble decides continuation
// [RULE_07] code 1,0 in dual-i/o skips opcode
// [RULE_08] any other code needs full opcode next
// [RULE_09] host releases lines before first data fall
// [RULE_10] reset opcode clears stored continuation state
// [RULE_11] quad-output read: address, dummy, four-bit data
// [RULE_12] any start byte, address increments per byte
// [RULE_13] quad-i/o: address, mode, two dummy bytes
// [RULE_14] quad data: high nibble first, two clocks
// [RULE_15] quad-i/o runs only with quad enable set
// [RULE_16] code 1,0 in quad-i/o skips opcode
// [RULE_17] opcode is eight single-line clocks
// [RULE_18] dual-i/o: address twelve, mode four clocks
// [RULE_19] quad-i/o: address six, mode two clocks
// [RULE_20] continuation state cleared by reset
`timescale 1ns/100ps
`include "flash_read_defines.vh"
module multi_io_flash_read_path #(
    parameter [7:0] MODE_RESET_OPCODE = `OP_MODE_RESET
) (
    input  wire                     core_clk_i,
    input  wire                     rst_i,
    input  wire                     cs_n_i,
    input  wire                     sck_i,
    input  wire [3:0]               io_i,
    output reg  [3:0]               io_o,
    output reg  [3:0]               io_oe_n_o,
    input  wire                     quad_enable_bit_i,
    output reg  [`ARRAY_ADDR_W-1:0] mem_addr_o,
    input  wire [7:0]               mem_data_i,
    output reg                      cont_mode_o
);
    // one-hot phase states
    localparam [6:0] ST_IDLE   = 7'h01;
    localparam [6:0] ST_CMD    = 7'h02;
    localparam [6:0] ST_ADDR   = 7'h04;
    localparam [6:0] ST_MODE   = 7'h08;
    localparam [6:0] ST_DUMMY  = 7'h10;
    localparam [6:0] ST_DATA   = 7'h20;
    localparam [6:0] ST_IGNORE = 7'h40;

    wire [5:0] pins_sync;
    wire       cs_n_s;
    wire       sck_s;
    wire [3:0] pin_io;

    reg  [6:0]  state;
    reg  [4:0]  cnt;
    reg  [23:0] in_shift;
    reg  [7:0]  cmd;
    reg  [7:0]  out_shift;
    reg  [1:0]  slot;
    reg         sck_d;
    reg  [4:0]  frame_rises;
    reg  [7:0]  lane0_shift;

    reg  [2:0]  addr_lanes;
    reg  [2:0]  data_lanes;
    reg  [4:0]  addr_len;
    reg  [4:0]  mode_len;
    reg  [4:0]  dummy_len;
    reg  [2:0]  lanes;
    reg  [23:0] next_shift;
    reg  [7:0]  cur_byte;
    reg         op_known;
    wire [7:0]  op_byte;
    wire        sck_rise;
    wire        sck_fall;
    wire [1:0]  last_slot;

    // every pin, clock included, is sampled by the core clock
    pin_sync #(
        .WIDTH (6)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      ({cs_n_i, sck_i, io_i}),
        .sync_o     (pins_sync)
    );

    assign cs_n_s = pins_sync[5];
    assign sck_s  = pins_sync[4];
    assign pin_io = pins_sync[3:0];

    // edges of the synchronised serial clock; data and clock share latency
    assign sck_rise  = sck_s & ~sck_d;
    assign sck_fall  = ~sck_s & sck_d;
    assign op_byte   = {in_shift[6:0], pin_io[0]};
    assign last_slot = (data_lanes == 3'd2) ? 2'h3 : 2'h1;

    // phase geometry of the active read command
    always @* begin
        case (cmd)
            `OP_DUAL_IO: begin
                addr_lanes = 3'd2;                              // RULE_05
                data_lanes = 3'd2;
                addr_len   = `ADDR_CLKS_X2;                     // RULE_18
                mode_len   = `MODE_CLKS_X2;                     // RULE_18
                dummy_len  = 5'd0;
            end
            `OP_QUAD_OUT: begin
                addr_lanes = 3'd1;                              // RULE_11
                data_lanes = 3'd4;
                addr_len   = `ADDR_CLKS_X1;
                mode_len   = 5'd0;
                dummy_len  = `DUMMY_CLKS_X1;
            end
            `OP_QUAD_IO: begin
                addr_lanes = 3'd4;                              // RULE_13
                data_lanes = 3'd4;
                addr_len   = `ADDR_CLKS_X4;                     // RULE_19
                mode_len   = `MODE_CLKS_X4;                     // RULE_19
                dummy_len  = `DUMMY_CLKS_X4;                    // RULE_13
            end
            default: begin
                addr_lanes = 3'd1;                              // RULE_01
                data_lanes = 3'd2;
                addr_len   = `ADDR_CLKS_X1;
                mode_len   = 5'd0;
                dummy_len  = `DUMMY_CLKS_X1;
            end
        endcase
    end

    // incoming shift: msb on the highest used line
    always @* begin
        lanes = (state == ST_CMD) ? 3'd1 : addr_lanes;
        case (lanes)
            3'd1:    next_shift = {in_shift[22:0], pin_io[0]};
            3'd2:    next_shift = {in_shift[21:0], pin_io[1:0]};
            default: next_shift = {in_shift[19:0], pin_io[3:0]};
        endcase
    end

    // opcodes this path serves; quad-i/o needs the enable bit
    always @* begin
        case (op_byte)
            `OP_DUAL_OUT: op_known = 1'b1;
            `OP_DUAL_IO:  op_known = 1'b1;
            `OP_QUAD_OUT: op_known = 1'b1;
            `OP_QUAD_IO:  op_known = quad_enable_bit_i;         // RULE_15
            default:      op_known = 1'b0;
        endcase
    end

    // byte being shifted out: fresh from the array at slot zero
    always @* begin
        cur_byte = (slot == 2'h0) ? mem_data_i : out_shift;
    end

    // serial clock edge history
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            sck_d <= 1'b1;                                      // same level as the sync reset
        end else begin
            sck_d <= sck_s;
        end
    end

    // phase sequencer, input capture and continuation state
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            state       <= ST_IDLE;
            cnt         <= 5'd0;
            in_shift    <= 24'h000000;
            cmd         <= `OP_DUAL_OUT;
            cont_mode_o <= 1'b0;                                // RULE_20
            mem_addr_o  <= `ARRAY_FIRST;
            frame_rises <= 5'd0;
            lane0_shift <= 8'h00;
        end else if (cs_n_s) begin
            state       <= ST_IDLE;                             // RULE_04
            cnt         <= 5'd0;
            frame_rises <= 5'd0;
            // bare eight-clock reset command; in dual-i/o continuation it arrives as a cut address, in quad-i/o as address and mode
            if (frame_rises == 5'd8 && lane0_shift == MODE_RESET_OPCODE) begin
                cont_mode_o <= 1'b0;                            // RULE_10
            end
        end else begin
            // line zero and clock count kept in every phase, for the reset command
            if (sck_rise) begin
                lane0_shift <= {lane0_shift[6:0], pin_io[0]};
                if (frame_rises != 5'h1F) begin
                    frame_rises <= frame_rises + 5'd1;
                end
            end
            case (state)
                ST_IDLE: begin
                    cnt <= 5'd0;
                    // stored code 1,0 means the address comes first
                    if (cont_mode_o && (cmd != `OP_QUAD_IO || quad_enable_bit_i)) begin
                        state <= ST_ADDR;                       // RULE_07 RULE_16
                    end else if (cont_mode_o) begin
                        state <= ST_IGNORE;                     // RULE_15
                    end else begin
                        state <= ST_CMD;                        // RULE_08
                    end
                end
                ST_CMD: begin
                    if (sck_rise) begin
                        in_shift <= next_shift;
                        cnt      <= cnt + 5'd1;
                        if (cnt == `CMD_CLKS - 5'd1) begin      // RULE_17
                            cnt <= 5'd0;
                            if (op_known) begin
                                cmd   <= op_byte;
                                state <= ST_ADDR;
                            end else begin
                                state <= ST_IGNORE;
                            end
                            if (op_byte == MODE_RESET_OPCODE) begin
                                cont_mode_o <= 1'b0;            // RULE_10
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        in_shift <= next_shift;
                        cnt      <= cnt + 5'd1;
                        if (cnt == addr_len - 5'd1) begin
                            cnt <= 5'd0;
                            // top address bits lie beyond the array
                            mem_addr_o <= next_shift[`ARRAY_ADDR_W-1:0]; // RULE_12
                            if (mode_len != 5'd0) begin
                                state <= ST_MODE;
                            end else if (dummy_len != 5'd0) begin
                                state <= ST_DUMMY;
                            end else begin
                                state <= ST_DATA;
                            end
                        end
                    end
                end
                ST_MODE: begin
                    if (sck_rise) begin
                        in_shift <= next_shift;
                        cnt      <= cnt + 5'd1;
                        if (cnt == mode_len - 5'd1) begin
                            cnt <= 5'd0;
                            // low nibble is don't care; only bits 5:4 decide
                            cont_mode_o <= (next_shift[`CONT_FIELD_HI:`CONT_FIELD_LO]
                                            == `CONT_CODE);     // RULE_06 RULE_07 RULE_08
                            state <= (dummy_len != 5'd0) ? ST_DUMMY : ST_DATA;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sck_rise) begin
                        cnt <= cnt + 5'd1;
                        if (cnt == dummy_len - 5'd1) begin
                            cnt   <= 5'd0;
                            state <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    // step to the next byte as this one is loaded
                    if (sck_fall && slot == 2'h0) begin
                        if (mem_addr_o == `ARRAY_LAST) begin
                            mem_addr_o <= `ARRAY_FIRST;         // RULE_03
                        end else begin
                            mem_addr_o <= mem_addr_o + 19'h00001; // RULE_12
                        end
                    end
                end
                ST_IGNORE: begin
                    cnt <= 5'd0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // output shifter: new bits on each falling edge of the data phase
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            io_o      <= 4'h0;
            io_oe_n_o <= `OE_NONE;
            out_shift <= 8'h00;
            slot      <= 2'h0;
        end else if (cs_n_s || state != ST_DATA) begin
            // released at once on deselect, even mid-byte
            io_oe_n_o <= `OE_NONE;                              // RULE_04
            slot      <= 2'h0;
        end else if (sck_fall) begin
            // host has let go of the lines before this edge
            slot <= (slot == last_slot) ? 2'h0 : slot + 2'h1;   // RULE_09
            if (data_lanes == 3'd2) begin
                io_o      <= {2'h0, cur_byte[7:6]};             // RULE_02
                out_shift <= {cur_byte[5:0], 2'h0};
                io_oe_n_o <= `OE_DUAL;
            end else begin
                io_o      <= cur_byte[7:4];                     // RULE_14
                out_shift <= {cur_byte[3:0], 4'h0};
                io_oe_n_o <= `OE_QUAD;
            end
        end
    end

endmodule // multi_io_flash_read_path

//--- tb/multi_io_flash_read_path_sva.sv
// port-level assertion checker for the multi-line flash read path
`timescale 1ns/100ps
`include "flash_read_defines.vh"
module multi_io_flash_read_path_sva (
    input wire                     core_clk_i,
    input wire                     rst_i,
    input wire                     cs_n_i,
    input wire                     sck_i,
    input wire [3:0]               io_i,
    input wire [3:0]               io_o,
    input wire [3:0]               io_oe_n_o,
    input wire                     quad_enable_bit_i,
    input wire [`ARRAY_ADDR_W-1:0] mem_addr_o,
    input wire [7:0]               mem_data_i,
    input wire                     cont_mode_o
);
    // single domain, so clock and reset are declared once
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    AST_OE_LEGAL: assert property (io_oe_n_o inside {`OE_NONE, `OE_DUAL, `OE_QUAD})
        else $error("output enable pattern not idle, dual or quad");
    AST_RESET_STATE: assert property ($fell(rst_i) |-> io_oe_n_o == `OE_NONE
        && !cont_mode_o && mem_addr_o == `ARRAY_FIRST) else $error("state not cleared by reset");
    AST_CS_RELEASE: assert property (cs_n_i [*6] |-> io_oe_n_o == `OE_NONE)
        else $error("lines still driven after chip select high");
    AST_OE_IN_FRAME: assert property (io_oe_n_o != `OE_NONE && $past(io_oe_n_o) == `OE_NONE
        |-> !cs_n_i && !$past(cs_n_i, 3)) else $error("drive started outside a frame");
    AST_CONT_IN_FRAME: assert property ($changed(cont_mode_o) |-> !$past(cs_n_i, 4))
        else $error("continuation state moved outside a frame");
    // after the first byte every address move is one step, wrapping at the top
    AST_ADDR_STEP: assert property ($changed(mem_addr_o) && $past(io_oe_n_o) != `OE_NONE
        |-> mem_addr_o == $past(mem_addr_o) + 1'b1) else $error("address did not step by one");
    AST_DUAL_DATA: assert property ($changed(mem_addr_o) && io_oe_n_o == `OE_DUAL
        |-> io_o == {2'b00, $past(mem_data_i[7:6])}) else $error("dual byte not started msb first");
    AST_QUAD_DATA: assert property ($changed(mem_addr_o) && io_oe_n_o == `OE_QUAD
        |-> io_o == $past(mem_data_i[7:4])) else $error("quad byte not started high nibble");
    AST_IO_AFTER_FALL: assert property ($changed(io_o) |-> !sck_i && !$past(sck_i, 2))
        else $error("data changed away from a serial clock fall");

    COV_CONT: cover property ($rose(cont_mode_o));
    COV_WRAP: cover property ($past(mem_addr_o) == `ARRAY_LAST && mem_addr_o == `ARRAY_FIRST);
    COV_QUAD: cover property (io_oe_n_o == `OE_QUAD);
endmodule // multi_io_flash_read_path_sva

//--- tb/spi_host_model.sv
// partner model: spi host driving chip select, serial clock and data lines
`timescale 1ns/100ps
module spi_host_model (
    output logic       cs_n_o,
    output logic       sck_o,
    output logic [3:0] io_o,
    input  wire  [3:0] io_i
);
    logic [7:0] got [0:7];

    // deselected, clock parked low between frames
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        io_o = 4'h0;
    end

    // n clocks of w bits, msb on the highest line; rel lets go mid-way after the last rise
    task automatic send(input logic [23:0] v, input int n, input int w, input bit rel);
        for (int i = n - 1; i >= 0; i--) begin
            io_o = 4'((v >> (i * w)) & ((24'h1 << w) - 24'h1));
            #80 sck_o = 1'b1;
            #40 if (rel && i == 0) io_o = ~io_o;
            #40 sck_o = 1'b0;
        end
    endtask

    // one read frame; opcode 0 means a continuation frame without opcode
    task automatic frame(input logic [7:0] op, input int aw, input logic [23:0] a,
                         input int mw, input logic [7:0] m, input int dc, input int dw,
                         input int nc);
        logic [7:0] sh;
        sh = 8'h00;
        #1 cs_n_o = 1'b0;
        if (op != 8'h00) send({16'h0, op}, 8, 1, 1'b0);
        send(a, 24 / aw, aw, mw == 0);
        if (mw != 0) send({16'h0, m}, 8 / mw, mw, 1'b1);
        repeat (dc) begin
            #80 sck_o = 1'b1;
            #80 sck_o = 1'b0;
        end
        // sample at the rise, long after the device moved on the fall
        for (int i = 0; i < nc; i++) begin
            #80 sck_o = 1'b1;
            sh = (sh << dw) | (8'(io_i) & ((8'h1 << dw) - 8'h1));
            if ((i + 1) * dw % 8 == 0) got[(i + 1) * dw / 8 - 1] = sh;
            #80 sck_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        #399;
    endtask

    // bare eight-clock command on line zero, then deselect
    task automatic bare_cmd(input logic [7:0] op);
        #1 cs_n_o = 1'b0;
        send({16'h0, op}, 8, 1, 1'b0);
        #80 cs_n_o = 1'b1;
        #399;
    endtask
endmodule // spi_host_model

//--- tb/multi_io_flash_read_path_tb.sv
// self-checking bench for the multi-line flash read path
`timescale 1ns/100ps
`include "flash_read_defines.vh"
module multi_io_flash_read_path_tb;
    logic        core_clk_i;
    logic        rst_i = 1'b1;
    logic        quad_enable_bit = 1'b0;
    int          drive_cycles = 0;
    wire         cs_n;
    wire         sck;
    wire  [3:0]  host_io;
    wire  [3:0]  io_in;
    wire  [3:0]  io_out;
    wire  [3:0]  oe_n;
    wire  [18:0] mem_addr;
    wire  [7:0]  mem_data;
    wire         cont;
    int          bad_count = 0;
    int          compares = 0;

    function automatic logic [7:0] mv(input logic [18:0] a);
        return a[7:0] ^ a[15:8] ^ {a[18:16], 5'h00} ^ 8'h5A;
    endfunction

    // array contents follow the address; pin level from whoever drives it
    assign mem_data = mv(mem_addr);
    assign io_in = (oe_n & host_io) | (~oe_n & io_out);

    multi_io_flash_read_path i_multi_io_flash_read_path (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .io_i(io_in), .io_o(io_out),
        .io_oe_n_o(oe_n), .quad_enable_bit_i(quad_enable_bit), .mem_addr_o(mem_addr),
        .mem_data_i(mem_data), .cont_mode_o(cont));
    spi_host_model i_spi_host_model (.cs_n_o(cs_n), .sck_o(sck), .io_o(host_io), .io_i(io_in));

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // remembers any drive at all, for refused commands
    always @(posedge core_clk_i) if (oe_n !== 4'hF) drive_cycles <= drive_cycles + 1;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic chk_bytes(input logic [18:0] a, input int n);
        for (int i = 0; i < n; i++) chk("data", i_spi_host_model.got[i], mv(a + 19'(i)));
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rst_pulse();
        @(posedge core_clk_i) #1 rst_i = 1'b1;
        repeat (5) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        repeat (4) @(posedge core_clk_i);
        chk("reset", {oe_n, cont, 8'h0, mem_addr}, 32'hF0000000);
    endtask

    task automatic t_dual_out();
        i_spi_host_model.frame(`OP_DUAL_OUT, 1, 24'h07FFFE, 0, 8'h0, 8, 2, 16);
        chk_bytes(19'h7FFFE, 4);
        chk("oe", oe_n, 4'hF);
    endtask
    task automatic t_quad_out();
        i_spi_host_model.frame(`OP_QUAD_OUT, 1, 24'h012345, 0, 8'h0, 8, 4, 7);
        chk_bytes(19'h12345, 3);
        chk("oe", oe_n, 4'hF);
    endtask
    task automatic t_dual_io();
        i_spi_host_model.frame(`OP_DUAL_IO, 2, 24'h000100, 2, 8'h2F, 0, 2, 8);
        chk_bytes(19'h00100, 2);
        chk("cont", cont, 1);
        i_spi_host_model.frame(8'h00, 2, 24'h07FFFF, 2, 8'h10, 0, 2, 8);
        chk_bytes(19'h7FFFF, 2);
        chk("cont", cont, 0);
        i_spi_host_model.frame(`OP_DUAL_IO, 2, 24'h000200, 2, 8'hD3, 0, 2, 4);
        chk_bytes(19'h00200, 1);
    endtask
    task automatic t_quad_io();
        int seen_drive;
        seen_drive = drive_cycles;
        i_spi_host_model.frame(`OP_QUAD_IO, 4, 24'h000040, 4, 8'hA5, 4, 4, 4);
        chk("refused", drive_cycles - seen_drive, 0);
        chk("cont", cont, 0);
        @(posedge core_clk_i) #1 quad_enable_bit = 1'b1;
        i_spi_host_model.frame(`OP_QUAD_IO, 4, 24'h000040, 4, 8'hA5, 4, 4, 4);
        chk_bytes(19'h00040, 2);
        chk("cont", cont, 1);
        i_spi_host_model.frame(8'h00, 4, 24'h000003, 4, 8'h3F, 4, 4, 6);
        chk_bytes(19'h00003, 3);
        chk("cont", cont, 0);
    endtask
    task automatic t_reset();
        i_spi_host_model.frame(`OP_DUAL_IO, 2, 24'h000010, 2, 8'h2F, 0, 2, 0);
        chk("cont", cont, 1);
        i_spi_host_model.bare_cmd(`OP_MODE_RESET);
        chk("cont", cont, 0);
        i_spi_host_model.frame(`OP_DUAL_IO, 2, 24'h000010, 2, 8'h2F, 0, 2, 0);
        chk("cont", cont, 1);
        rst_pulse();
        i_spi_host_model.frame(`OP_DUAL_IO, 2, 24'h000010, 2, 8'h00, 0, 2, 4);
        chk_bytes(19'h00010, 1);
    endtask

    // main sequence, then the single closing point
    initial begin
        rst_pulse();
        t_dual_out();
        t_quad_out();
        t_dual_io();
        t_quad_io();
        t_reset();
        give_verdict();
    end
    // watchdog: all frames fit well inside this span
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end
endmodule // multi_io_flash_read_path_tb

bind multi_io_flash_read_path multi_io_flash_read_path_sva i_multi_io_flash_read_path_sva (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .io_i(io_i),
    .io_o(io_o), .io_oe_n_o(io_oe_n_o), .quad_enable_bit_i(quad_enable_bit_i),
    .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i), .cont_mode_o(cont_mode_o));
